// File: pps_pkg.sv
// package: register map, field positions and carriers for the phy port select block
`default_nettype none
package pps_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int ENDEC_W = 1;
   localparam int PHY_W = 4;
   // register addresses
   localparam logic [ADDR_W-1:0] A_CONFIG = 4'h0;
   localparam logic [ADDR_W-1:0] A_TXCTL  = 4'h1;
   localparam logic [ADDR_W-1:0] A_STATUS = 4'h2;
   localparam logic [ADDR_W-1:0] A_TXDATA = 4'h3;
   localparam logic [ADDR_W-1:0] A_RXDATA = 4'h4;
   // field positions
   localparam int B_PORT_SEL  = 15;
   localparam int B_FULL_STEP = 10;
   localparam int B_AUI_SEL   = 8;
   localparam int B_LOOP      = 1;
   localparam int B_LINK      = 14;
   localparam int B_BAD_CRC   = 13;
   localparam int B_COLL      = 12;
   localparam int B_MGMT_IN   = 3;
   localparam int B_CARRIER   = 2;
   localparam int B_RX_RDY    = 1;
   localparam int B_TX_BUSY   = 0;
   localparam int B_LAST      = 8;
   localparam int B_ERR       = 9;
   // writable masks and reset values
   localparam logic [DATA_W-1:0] CFG_MASK = 16'h8500;
   localparam logic [DATA_W-1:0] TCR_MASK = 16'h0002;
   localparam logic [DATA_W-1:0] CFG_RST  = 16'h0000;
   localparam logic [DATA_W-1:0] TCR_RST  = 16'h0000;
   typedef struct packed {
      logic       last;
      logic [7:0] data;
   } pps_txw_t;
   typedef struct packed {
      logic       err;
      logic       last;
      logic [7:0] data;
   } pps_rxw_t;
endpackage
`default_nettype wire

// File: pps_top.sv
// design: phy port select interface with serial and nibble link engines
//
// The address-and-strobe port and the address map were chosen for this implementation.
`default_nettype none

module pps_sync #(parameter int W = 1) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         nrst,
   // asynchronous level in, synchronised level out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_ff;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_ff <= '0;
         q       <= '0;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule

module pps_tx_eng #(parameter int W = 1, parameter logic WANT = 1'b0) (
   // link clock and reset
   input  wire logic             tclk,
   input  wire logic             nrst,
   // from the register side
   input  wire logic             sel,
   input  wire logic             req_tgl,
   input  wire pps_pkg::pps_txw_t txw,
   // link outputs and ack back
   output logic                  en,
   output logic      [W-1:0]     d,
   output logic                  ack_tgl
);
   import pps_pkg::*;
   localparam logic [3:0] STEPS_C = 4'(BYTE_W / W);
   logic       sel_s;
   logic       req_s;
   logic       sel_ok;
   logic       seen_ff;
   logic       busy_ff;
   logic       last_ff;
   logic [7:0] sh_ff;
   logic [3:0] cnt_ff;
   pps_sync u_sel (.clk(tclk), .nrst(nrst), .d(sel), .q(sel_s));
   pps_sync u_req (.clk(tclk), .nrst(nrst), .d(req_tgl), .q(req_s));
   assign sel_ok = (sel_s == WANT);
   // launch units on the link clock, low bits first
   always_ff @(posedge tclk or negedge nrst) begin
      if (!nrst) begin
         en      <= 1'b0;
         d       <= '0;
         ack_tgl <= 1'b0;
         seen_ff <= 1'b0;
         busy_ff <= 1'b0;
         last_ff <= 1'b0;
         sh_ff   <= 8'h00;
         cnt_ff  <= 4'h0;
      end else if (!sel_ok) begin
         en      <= 1'b0;
         d       <= '0;
         busy_ff <= 1'b0;
         seen_ff <= req_s;
         ack_tgl <= req_s;
      end else if (busy_ff) begin
         d      <= sh_ff[W-1:0];
         en     <= 1'b1;
         sh_ff  <= sh_ff >> W;
         cnt_ff <= cnt_ff - 4'h1;
         if (cnt_ff == 4'h1) begin
            busy_ff <= 1'b0;
            ack_tgl <= ~ack_tgl;
         end
      end else if (req_s != seen_ff) begin
         sh_ff   <= txw.data;
         cnt_ff  <= STEPS_C;
         busy_ff <= 1'b1;
         last_ff <= txw.last;
         seen_ff <= req_s;
      end else if (last_ff) begin
         en <= 1'b0;
      end
   end
   property p_off;
      @(posedge tclk) disable iff (!nrst) !sel_ok |=> !en;
   endproperty
   a_off: assert property (p_off) else $error("enable high on deselected port");
   property p_unit;
      @(posedge tclk) disable iff (!nrst)
         (busy_ff && sel_ok) |=> (en && d == $past(sh_ff[W-1:0]));
   endproperty
   a_unit: assert property (p_unit) else $error("unit not launched in order");
endmodule

module pps_rx_eng #(parameter int W = 1, parameter logic WANT = 1'b0) (
   // link clock and reset
   input  wire logic              rclk,
   input  wire logic              nrst,
   // port select from the register side
   input  wire logic              sel,
   // link inputs, synchronous to rclk
   input  wire logic              vld,
   input  wire logic [W-1:0]      d,
   input  wire logic              err,
   // word and event toggle to the register side
   output pps_pkg::pps_rxw_t      word,
   output logic                   tgl
);
   import pps_pkg::*;
   localparam logic [3:0] LAST_C = 4'(BYTE_W / W - 1);
   logic       sel_s;
   logic       sel_ok;
   logic       vld_d_ff;
   logic       pend_ff;
   logic       err_ff;
   logic [7:0] sh_ff;
   logic [7:0] pbyte_ff;
   logic [3:0] cnt_ff;
   logic [7:0] nxt_byte;
   pps_sync u_sel (.clk(rclk), .nrst(nrst), .d(sel), .q(sel_s));
   assign sel_ok = (sel_s == WANT);
   assign nxt_byte = {d, sh_ff[7:W]};
   // a byte is held until the next one or the envelope end tells if it is last
   always_ff @(posedge rclk or negedge nrst) begin
      if (!nrst) begin
         word     <= '0;
         tgl      <= 1'b0;
         vld_d_ff <= 1'b0;
         pend_ff  <= 1'b0;
         err_ff   <= 1'b0;
         sh_ff    <= 8'h00;
         pbyte_ff <= 8'h00;
         cnt_ff   <= 4'h0;
      end else begin
         vld_d_ff <= vld & sel_ok;
         if (vld && sel_ok) begin
            sh_ff  <= nxt_byte;
            err_ff <= err_ff | err;
            if (cnt_ff == LAST_C) begin
               cnt_ff   <= 4'h0;
               pbyte_ff <= nxt_byte;
               pend_ff  <= 1'b1;
               if (pend_ff && !(err_ff || err)) begin
                  word <= '{err: 1'b0, last: 1'b0, data: pbyte_ff};
                  tgl  <= ~tgl;
               end
            end else begin
               cnt_ff <= cnt_ff + 4'h1;
            end
         end else if (vld_d_ff) begin
            word    <= '{err: err_ff, last: 1'b1, data: (err_ff ? 8'h00 : pbyte_ff)};
            tgl     <= ~tgl;
            pend_ff <= 1'b0;
            err_ff  <= 1'b0;
            cnt_ff  <= 4'h0;
            sh_ff   <= 8'h00;
         end
      end
   end
   property p_quiet;
      @(posedge rclk) disable iff (!nrst) (!sel_ok && !vld_d_ff) |=> $stable(tgl);
   endproperty
   a_quiet: assert property (p_quiet) else $error("word from deselected port");
endmodule

module pps_top (
   // register side clock and resets
   input  wire logic                       clk,
   input  wire logic                       nrst,
   input  wire logic                       por_n,
   // register port
   input  wire logic [pps_pkg::ADDR_W-1:0] addr,
   input  wire logic [pps_pkg::DATA_W-1:0] wdata,
   input  wire logic                       wr,
   input  wire logic                       rd,
   output logic      [pps_pkg::DATA_W-1:0] rdata,
   // serial encoder/decoder port
   input  wire logic                       endec_tx_clock,
   input  wire logic                       endec_rx_clock,
   input  wire logic                       endec_carrier,
   input  wire logic                       endec_collision,
   input  wire logic                       endec_rx_data,
   output logic                            endec_tx_data,
   output logic                            endec_tx_enable,
   // MII port
   input  wire logic                       phy_tx_clock,
   input  wire logic                       phy_rx_clock,
   input  wire logic                       fast_carrier,
   input  wire logic                       fast_collision,
   input  wire logic                       fast_rx_valid,
   input  wire logic                       fast_rx_error,
   input  wire logic [3:0]                 fast_rx_data,
   output logic      [3:0]                 fast_tx_data,
   output logic                            fast_tx_enable,
   // port independent pins
   input  wire logic                       link_in_n,
   input  wire logic                       mgmt_data_in,
   output logic                            loopback_out,
   output logic                            full_step_out_n,
   output logic                            attach_unit_select_out,
   output logic                            port_select_out
);
   import pps_pkg::*;
   logic [DATA_W-1:0] cfg_ff;
   logic [DATA_W-1:0] tcr_ff;
   logic [DATA_W-1:0] rd_val;
   logic              ecar_s, ecol_s, fcar_s, fcol_s, nlink_s, mgmt_s;
   logic              eack_s, pack_s, erx_s, prx_s;
   logic              eack_t, pack_t, erx_t, prx_t;
   logic              e_en, p_en;
   pps_rxw_t          erx_w, prx_w;
   logic              car_s, col_s;
   pps_txw_t          txw_ff;
   logic              tx_req_ff, tx_hold_ff, tx_first_ff;
   logic              tx_ack, tx_pend, launch;
   logic              erx_seen_ff, prx_seen_ff;
   logic              rx_take;
   pps_rxw_t          rx_in;
   pps_rxw_t          rxw_ff;
   logic              rx_rdy_ff, bad_ff, coll_ff;
   logic              nxt_rx_rdy, nxt_bad, nxt_coll;
   logic              wr_stat, rd_rx;

   pps_sync #(.W(6)) u_pins (.clk(clk), .nrst(nrst),
      .d({endec_carrier, endec_collision, fast_carrier, fast_collision, link_in_n, mgmt_data_in}),
      .q({ecar_s, ecol_s, fcar_s, fcol_s, nlink_s, mgmt_s}));
   pps_sync #(.W(4)) u_tgl (.clk(clk), .nrst(nrst),
      .d({eack_t, pack_t, erx_t, prx_t}), .q({eack_s, pack_s, erx_s, prx_s}));

   pps_tx_eng #(.W(ENDEC_W), .WANT(1'b0)) u_etx (.tclk(endec_tx_clock), .nrst(nrst),
      .sel(port_select_out), .req_tgl(tx_req_ff), .txw(txw_ff),
      .en(e_en), .d(endec_tx_data), .ack_tgl(eack_t));
   pps_tx_eng #(.W(PHY_W), .WANT(1'b1)) u_ptx (.tclk(phy_tx_clock), .nrst(nrst),
      .sel(port_select_out), .req_tgl(tx_req_ff), .txw(txw_ff),
      .en(p_en), .d(fast_tx_data), .ack_tgl(pack_t));
   pps_rx_eng #(.W(ENDEC_W), .WANT(1'b0)) u_erx (.rclk(endec_rx_clock), .nrst(nrst),
      .sel(port_select_out), .vld(endec_carrier), .d(endec_rx_data), .err(1'b0),
      .word(erx_w), .tgl(erx_t));
   pps_rx_eng #(.W(PHY_W), .WANT(1'b1)) u_prx (.rclk(phy_rx_clock), .nrst(nrst),
      .sel(port_select_out), .vld(fast_rx_valid), .d(fast_rx_data), .err(fast_rx_error),
      .word(prx_w), .tgl(prx_t));

   // pin outputs straight from configuration and transmit control; link enables gated by port select
   assign port_select_out        = cfg_ff[B_PORT_SEL];
   assign full_step_out_n        = ~cfg_ff[B_FULL_STEP];
   assign attach_unit_select_out = cfg_ff[B_AUI_SEL];
   assign loopback_out           = tcr_ff[B_LOOP];
   assign endec_tx_enable        = e_en & ~port_select_out;
   assign fast_tx_enable         = p_en & port_select_out;

   // only the live port's envelopes count
   assign car_s = port_select_out ? fcar_s : ecar_s;
   assign col_s = port_select_out ? fcol_s : ecol_s;

   // configuration survives the ordinary reset
   always_ff @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         cfg_ff <= CFG_RST;
      end else if (wr && addr == A_CONFIG) begin
         cfg_ff <= wdata & CFG_MASK;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tcr_ff <= TCR_RST;
      end else if (wr && addr == A_TXCTL) begin
         tcr_ff <= wdata & TCR_MASK;
      end
   end

   // transmit hand-off, deferring a frame start while carrier is up
   assign tx_ack  = port_select_out ? pack_s : eack_s;
   assign tx_pend = tx_hold_ff | (tx_req_ff != tx_ack);
   assign launch  = tx_hold_ff && !(tx_first_ff && car_s);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         txw_ff      <= '0;
         tx_req_ff   <= 1'b0;
         tx_hold_ff  <= 1'b0;
         tx_first_ff <= 1'b1;
      end else if (launch) begin
         tx_req_ff   <= ~tx_req_ff;
         tx_hold_ff  <= 1'b0;
         tx_first_ff <= txw_ff.last;
      end else if (wr && addr == A_TXDATA && !tx_pend) begin
         txw_ff     <= '{last: wdata[B_LAST], data: wdata[7:0]};
         tx_hold_ff <= 1'b1;
      end
   end

   // receive words from the selected engine only
   assign rx_take = port_select_out ? (prx_s != prx_seen_ff) : (erx_s != erx_seen_ff);
   assign rx_in   = port_select_out ? prx_w : erx_w;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         erx_seen_ff <= 1'b0;
         prx_seen_ff <= 1'b0;
         rxw_ff      <= '0;
      end else begin
         erx_seen_ff <= erx_s;
         prx_seen_ff <= prx_s;
         if (rx_take) begin
            rxw_ff <= rx_in;
         end
      end
   end

   // sticky status, a new event beats a clear in the same cycle
   assign wr_stat    = wr && addr == A_STATUS;
   assign rd_rx      = rd && addr == A_RXDATA;
   assign nxt_rx_rdy = rx_take | (rx_rdy_ff & ~rd_rx);
   assign nxt_bad    = (rx_take & rx_in.err) | (bad_ff & ~(wr_stat & wdata[B_BAD_CRC]));
   assign nxt_coll   = (col_s & tx_pend) | (coll_ff & ~(wr_stat & wdata[B_COLL]));
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_rdy_ff <= 1'b0;
         bad_ff    <= 1'b0;
         coll_ff   <= 1'b0;
      end else begin
         rx_rdy_ff <= nxt_rx_rdy;
         bad_ff    <= nxt_bad;
         coll_ff   <= nxt_coll;
      end
   end

   always_comb begin
      rd_val = '0;
      case (addr)
         A_CONFIG: rd_val = cfg_ff;
         A_TXCTL:  rd_val = tcr_ff;
         A_STATUS: begin
            rd_val[B_LINK]    = ~nlink_s;
            rd_val[B_BAD_CRC] = bad_ff;
            rd_val[B_COLL]    = coll_ff;
            rd_val[B_MGMT_IN] = mgmt_s;
            rd_val[B_CARRIER] = car_s;
            rd_val[B_RX_RDY]  = rx_rdy_ff;
            rd_val[B_TX_BUSY] = tx_pend;
         end
         A_RXDATA: rd_val = {6'h00, rxw_ff.err, rxw_ff.last, rxw_ff.data};
         default:  rd_val = '0;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= '0;
      end else begin
         rdata <= rd ? rd_val : '0;
      end
   end

   property p_sel;
      @(posedge clk) disable iff (!nrst)
         (wr && addr == A_CONFIG) |=> port_select_out == $past(wdata[B_PORT_SEL]);
   endproperty
   a_sel: assert property (p_sel) else $error("port select not updated");
   property p_step;
      @(posedge clk) disable iff (!nrst)
         (wr && addr == A_CONFIG) |=> full_step_out_n == !$past(wdata[B_FULL_STEP]);
   endproperty
   a_step: assert property (p_step) else $error("full step not inverse");
   property p_aui;
      @(posedge clk) disable iff (!nrst)
         (wr && addr == A_CONFIG) |=> attach_unit_select_out == $past(wdata[B_AUI_SEL]);
   endproperty
   a_aui: assert property (p_aui) else $error("attach select not updated");
   property p_loop;
      @(posedge clk) disable iff (!nrst)
         (wr && addr == A_TXCTL) |=> loopback_out == $past(wdata[B_LOOP]);
   endproperty
   a_loop: assert property (p_loop) else $error("loopback not updated");
   property p_link;
      @(posedge clk) disable iff (!nrst)
         (rd && addr == A_STATUS) |=> rdata[B_LINK] == !$past(nlink_s);
   endproperty
   a_link: assert property (p_link) else $error("link flag wrong");
   property p_fast_off;
      @(posedge clk) disable iff (!nrst) (!port_select_out) [*4] |-> !p_en;
   endproperty
   a_fast_off: assert property (p_fast_off) else $error("fast enable on serial port");
   property p_ign_ser;
      @(posedge clk) disable iff (!nrst)
         (port_select_out && erx_s != erx_seen_ff && prx_s == prx_seen_ff && !rx_rdy_ff)
         |=> !rx_rdy_ff;
   endproperty
   a_ign_ser: assert property (p_ign_ser) else $error("serial word taken in MII mode");
   property p_ign_mii;
      @(posedge clk) disable iff (!nrst)
         (!port_select_out && prx_s != prx_seen_ff && erx_s == erx_seen_ff && !rx_rdy_ff)
         |=> !rx_rdy_ff;
   endproperty
   a_ign_mii: assert property (p_ign_mii) else $error("MII word taken in serial mode");
   property p_defer;
      @(posedge clk) disable iff (!nrst)
         (tx_hold_ff && tx_first_ff && car_s) |=> (tx_hold_ff && $stable(tx_req_ff));
   endproperty
   a_defer: assert property (p_defer) else $error("frame started under carrier");
   property p_bad;
      @(posedge clk) disable iff (!nrst) (rx_take && rx_in.err) |=> (bad_ff && rxw_ff.err);
   endproperty
   a_bad: assert property (p_bad) else $error("code error not reported");
   c_launch: cover property (@(posedge clk) disable iff (!nrst) launch ##[1:40] !tx_pend);
   c_rx: cover property (@(posedge clk) disable iff (!nrst) rx_take && rx_in.last);
   c_bad: cover property (@(posedge clk) disable iff (!nrst) rx_take && rx_in.err);
endmodule
`default_nettype wire

// File: pps_phy_model.sv
// far-side model: serial encoder/decoder and MII PHY
`default_nettype none
module pps_phy_model (
   // serial encoder/decoder side
   output logic       endec_tx_clock,
   output logic       endec_rx_clock,
   output logic       endec_carrier,
   output logic       endec_collision,
   output logic       endec_rx_data,
   input  wire logic  endec_tx_data,
   input  wire logic  endec_tx_enable,
   // MII PHY side
   output logic       phy_tx_clock,
   output logic       phy_rx_clock,
   output logic       fast_carrier,
   output logic       fast_collision,
   output logic       fast_rx_valid,
   output logic       fast_rx_error,
   output logic [3:0] fast_rx_data,
   input  wire logic  [3:0] fast_tx_data,
   input  wire logic  fast_tx_enable
);
   timeunit 1ns;
   timeprecision 100ps;
   int ser_q[$];
   int mii_q[$];
   initial begin
      endec_rx_clock = 1'b0;
      endec_carrier = 1'b0;
      endec_collision = 1'b0;
      endec_rx_data = 1'b1;
      phy_rx_clock = 1'b0;
      fast_carrier = 1'b0;
      fast_collision = 1'b0;
      fast_rx_valid = 1'b0;
      fast_rx_error = 1'b0;
      fast_rx_data = 4'h0;
   end
   initial begin
      endec_tx_clock = 1'b0;
      #5;
      forever #7.5 endec_tx_clock = ~endec_tx_clock;
   end
   initial begin
      phy_tx_clock = 1'b0;
      #3;
      forever #7.5 phy_tx_clock = ~phy_tx_clock;
   end
   always @(posedge endec_tx_clock) if (endec_tx_enable) ser_q.push_back(endec_tx_data);
   always @(posedge phy_tx_clock) if (fast_tx_enable) mii_q.push_back(fast_tx_data);
   // one receive unit with its own clock pulse; released lines do not hold data
   task rx_unit(input bit mii, input logic [3:0] u, input logic v, input logic e);
      if (mii) begin
         fast_rx_valid = v;
         fast_rx_error = e;
         fast_rx_data = v ? u : ~fast_rx_data;
         #7.5 phy_rx_clock = 1'b1;
         #7.5 phy_rx_clock = 1'b0;
      end else begin
         endec_carrier = v;
         endec_rx_data = v ? u[0] : 1'b1;
         #7.5 endec_rx_clock = 1'b1;
         #7.5 endec_rx_clock = 1'b0;
      end
   endtask
   task send(input bit mii, input logic [7:0] b, input int err_at);
      int n;
      n = mii ? 2 : 8;
      repeat (3) rx_unit(mii, 4'h0, 1'b0, 1'b0);
      for (int i = 0; i < n; i++) begin
         rx_unit(mii, mii ? b[4*i+:4] : {3'h0, b[i]}, 1'b1, i == err_at);
      end
      repeat (4) rx_unit(mii, 4'h0, 1'b0, 1'b0);
   endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// testbench: register port, both link ports and port-independent pins
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import pps_pkg::*;
   logic        clk, nrst, por_n, wr, rd, link_in_n, mgmt_data_in;
   logic [3:0]  addr, fast_rx_data, fast_tx_data;
   logic [15:0] wdata, rdata, s;
   logic [31:0] v;
   logic        endec_tx_clock, endec_rx_clock, endec_carrier, endec_collision;
   logic        endec_rx_data, endec_tx_data, endec_tx_enable;
   logic        phy_tx_clock, phy_rx_clock, fast_carrier, fast_collision;
   logic        fast_rx_valid, fast_rx_error, fast_tx_enable;
   logic        loopback_out, full_step_out_n, attach_unit_select_out, port_select_out;
   int          num_errors, checks_done, cfg_m, loop_m;
   pps_top pps_top_i (.clk, .nrst, .por_n, .addr, .wdata, .wr, .rd, .rdata,
      .endec_tx_clock, .endec_rx_clock, .endec_carrier, .endec_collision, .endec_rx_data,
      .endec_tx_data, .endec_tx_enable, .phy_tx_clock, .phy_rx_clock, .fast_carrier,
      .fast_collision, .fast_rx_valid, .fast_rx_error, .fast_rx_data, .fast_tx_data,
      .fast_tx_enable, .link_in_n, .mgmt_data_in, .loopback_out, .full_step_out_n,
      .attach_unit_select_out, .port_select_out);
   pps_phy_model phy_i (.endec_tx_clock, .endec_rx_clock, .endec_carrier, .endec_collision,
      .endec_rx_data, .endec_tx_data, .endec_tx_enable, .phy_tx_clock, .phy_rx_clock,
      .fast_carrier, .fast_collision, .fast_rx_valid, .fast_rx_error, .fast_rx_data,
      .fast_tx_data, .fast_tx_enable);
   always #10 clk = ~clk;
   task end_of_test;
      if (num_errors == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task chk(input string what, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask
   task wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task chk_pins;
      chk("pins", {12'h0, loop_m[B_LOOP], cfg_m[B_PORT_SEL], ~cfg_m[B_FULL_STEP],
         cfg_m[B_AUI_SEL]}, {12'h0, loopback_out, port_select_out, full_step_out_n,
         attach_unit_select_out});
   endtask
   task set_cfg(input logic [15:0] d);
      wr_reg(A_CONFIG, d);
      cfg_m = d & CFG_MASK;
      chk_pins;
   endtask
   task tx_test(input logic [7:0] b, input bit defer);
      int i;
      int got;
      int k;
      if (defer) begin
         phy_i.fast_carrier = 1'b1;
         phy_i.fast_collision = 1'b1;
      end
      wr_reg(A_TXDATA, {7'h0, 1'b1, b});
      if (defer) begin
         repeat (20) @(posedge clk);
         rd_reg(A_STATUS, s);
         chk("defer busy carrier", 16'h1005, s & 16'h1005);
         chk("units while deferred", 16'h0, 16'(phy_i.mii_q.size()));
         phy_i.fast_carrier = 1'b0;
         phy_i.fast_collision = 1'b0;
      end
      k = 0;
      s = 16'h0001;
      while (s[B_TX_BUSY] !== 1'b0 && k < 100) begin
         rd_reg(A_STATUS, s);
         k++;
      end
      chk("tx busy", 16'h0, {15'h0, s[B_TX_BUSY]});
      if (defer) begin
         wr_reg(A_STATUS, 16'h1000);
         rd_reg(A_STATUS, s);
         chk("collision clear", 16'h0, s & 16'h1000);
      end
      repeat (6) @(posedge clk);
      got = 0;
      i = 0;
      if (cfg_m[B_PORT_SEL]) while (phy_i.mii_q.size() > 0) begin
         got |= phy_i.mii_q.pop_front() << (4 * i);
         i++;
      end else while (phy_i.ser_q.size() > 0) begin
         got |= phy_i.ser_q.pop_front() << i;
         i++;
      end
      chk("tx unit count", cfg_m[B_PORT_SEL] ? 16'h2 : 16'h8, 16'(i));
      chk("tx byte", {8'h00, b}, 16'(got));
      chk("idle port units", 16'h0, 16'(phy_i.mii_q.size() + phy_i.ser_q.size()));
   endtask
   task rx_test(input bit mii, input logic [7:0] b, input int ea);
      bit live;
      live = (mii == cfg_m[B_PORT_SEL]);
      phy_i.send(mii, b, ea);
      repeat (6) @(posedge clk);
      rd_reg(A_STATUS, s);
      chk("rx ready", {15'h0, live}, {15'h0, s[B_RX_RDY]});
      chk("bad frame flag", {15'h0, ea < 2}, {15'h0, s[B_BAD_CRC]});
      if (live) begin
         rd_reg(A_RXDATA, s);
         chk("rx word", (ea < 2) ? 16'h0300 : {8'h01, b}, s);
      end
      if (ea < 2) wr_reg(A_STATUS, 16'h2000);
   endtask
   initial begin
      #1ms;
      num_errors++;
      end_of_test;
   end
   initial begin
      clk = 0;
      nrst = 0;
      por_n = 0;
      addr = 4'h0;
      wdata = 16'h0000;
      wr = 0;
      rd = 0;
      link_in_n = 1;
      mgmt_data_in = 0;
      num_errors = 0;
      checks_done = 0;
      cfg_m = 0;
      loop_m = 0;
      void'($urandom(36));
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      por_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk_pins;
      rd_reg(A_CONFIG, s);
      chk("config reset", CFG_RST, s);
      for (int i = 0; i < 6; i++) begin
         v = $urandom;
         set_cfg(v[15:0]);
         wr_reg(A_TXCTL, v[31:16]);
         loop_m = v[31:16] & TCR_MASK;
         chk_pins;
         rd_reg(A_CONFIG, s);
         chk("config", 16'(cfg_m), s);
         @(posedge clk);
         link_in_n <= v[3];
         mgmt_data_in <= v[4];
         repeat (4) @(posedge clk);
         rd_reg(A_STATUS, s);
         chk("status pins", {14'h0, ~v[3], v[4]}, {14'h0, s[B_LINK], s[B_MGMT_IN]});
      end
      wr_reg(A_TXCTL, 16'h0000);
      loop_m = 0;
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      #1 chk_pins;
      for (int p = 0; p < 2; p++) begin
         set_cfg(p ? 16'h8000 : 16'h0000);
         repeat (2) begin
            v = $urandom;
            tx_test(v[7:0], 1'b0);
         end
         for (int m = 0; m < 2; m++) begin
            v = $urandom;
            rx_test(m[0], v[7:0], 99);
         end
      end
      v = $urandom;
      tx_test(v[7:0], 1'b1);
      rx_test(1'b1, v[15:8], 1);
      end_of_test;
   end
endmodule
`default_nettype wire
